// ### hdl/fh_host.sv
// ---------------------------------------------------------------------------
// fh_host.sv
// ---------------------------------------------------------------------------
// host controller for a byte-wide parallel flash: array reads, standby,
// wake-up and identifier access by high voltage or by command.
// assumes the data pins are joined by the bench from dq_o, dq_oe and dq_i.
`include "fh_cfg.svh"

module fh_host
  import fh_pkg::*;
#(
  parameter int ACC_CYC  = `FH_ACC_CYC,
  parameter int WAKE_CYC = `FH_WAKE_CYC,
  parameter int WP_CYC   = `FH_WP_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire fh_req_t               req,
  output      logic                  ready,
  output      fh_rsp_t               rsp,
  output      logic [`FH_ADDR_W-1:0] f_addr,
  output      logic                  f_ce_b,
  output      logic                  f_oe_b,
  output      logic                  f_we_b,
  output      logic                  f_reset_b,
  output      logic [7:0]            f_dq_o,
  output      logic                  f_dq_oe,
  input  wire logic [7:0]            f_dq_i,
  output      logic                  hv_id_en
);

  // ---------------------------------------------------------------------------
  // constants at the width of the counter
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RD_WAIT   = 8'(ACC_CYC + `FH_SYNC_CYC);
  localparam logic [7:0] WAKE_WAIT = 8'(WAKE_CYC);
  localparam logic [7:0] WP_WAIT   = 8'(WP_CYC);
  localparam logic [7:0] GAP_WAIT  = 8'(`FH_GAP_CYC);

  fh_st_t      st_r;     // registered state
  fh_st_t      st_nxt;   // next state
  logic [7:0]  dq_sync;  // settled data pins
  logic [18:0] cw_first; // first write of a requested command sequence
  logic [18:0] cw_next;  // write that follows the current step

  // ---------------------------------------------------------------------------
  // data pin synchroniser
  // ---------------------------------------------------------------------------
  fh_pin_sync #(
    .W (8)
  ) u_sync (
    .clk    (clk),
    .rst_b  (rst_b),
    .pin_i  (f_dq_i),
    .sync_o (dq_sync)
  );

  // command word for a given write step: {low address, data}
  function automatic logic [18:0] cmd_word(input fh_op_t op, input logic [1:0] step);
    logic [18:0] w;
    w = {`FH_RESET_A, `FH_RESET_D};
    if (op == FH_OP_ID_ON) begin
      unique case (step)
        2'h0:    w = {`FH_UNLOCK1_A, `FH_UNLOCK1_D};
        2'h1:    w = {`FH_UNLOCK2_A, `FH_UNLOCK2_D};
        default: w = {`FH_UNLOCK1_A, `FH_IDCMD_D};
      endcase
    end
    return w;
  endfunction : cmd_word

  // address of an identifier read: only the three low select lines and the
  // group bits matter; the rest is driven low for a quiet bus
  function automatic logic [`FH_ADDR_W-1:0] id_addr(input fh_id_t sel, input logic [2:0] grp);
    logic [`FH_ADDR_W-1:0] a;
    a = '0;
    a[`FH_ADDR_W-1:`FH_GRP_LSB] = grp;
    a[`FH_LOW_SEL_BIT]          = 1'b0;
    a[`FH_PAGE_BIT]             = (sel == FH_ID_PROT);
    a[`FH_BYTE_BIT]             = (sel == FH_ID_DEVICE);
    return a;
  endfunction : id_addr

  // command words held in nets, since a function result cannot be sliced
  assign cw_first = cmd_word(req.op, 2'h0);
  assign cw_next  = cmd_word(st_r.op, st_r.step + 2'h1);

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.rsp.done = 1'b0;
    unique case (st_r.state)
      // wait for a request; flash rests deselected, reset as the last sleep or wake left it
      FH_S_IDLE: begin
        if (req.valid) begin
          st_nxt.op = req.op;
          case (req.op)
            FH_OP_READ, FH_OP_ID: begin
              st_nxt.pins.ce_b  = 1'b0;
              st_nxt.pins.oe_b  = 1'b0;
              st_nxt.pins.dq_oe = 1'b0;
              st_nxt.pins.addr  = (req.op == FH_OP_READ) ? req.addr
                                  : id_addr(req.id_sel, req.group);
              st_nxt.cnt        = RD_WAIT;
              st_nxt.state      = FH_S_RD;
            end
            FH_OP_ID_ON, FH_OP_ID_OFF: begin
              st_nxt.step       = 2'h0;
              st_nxt.pins.addr  = {10'h000, cw_first[18:8]};
              st_nxt.pins.dq_o  = cw_first[7:0];
              st_nxt.pins.dq_oe = 1'b1;
              st_nxt.pins.oe_b  = 1'b1;
              st_nxt.pins.ce_b  = 1'b0;
              st_nxt.pins.we_b  = 1'b0;
              st_nxt.cnt        = WP_WAIT;
              st_nxt.state      = FH_S_WR;
            end
            FH_OP_HV_ON, FH_OP_HV_OFF: begin
              st_nxt.pins.hv_id_en = (req.op == FH_OP_HV_ON);
              st_nxt.rsp.done      = 1'b1;
            end
            FH_OP_SLEEP: begin
              st_nxt.pins.reset_b = 1'b0;
              st_nxt.rsp.done     = 1'b1;
            end
            default: begin
              st_nxt.pins.reset_b = 1'b1;
              st_nxt.cnt          = WAKE_WAIT;
              st_nxt.state        = FH_S_WAKE;
            end
          endcase
        end
      end
      // read: hold select and gate until data has settled through the sync
      FH_S_RD: begin
        if (st_r.cnt == 8'h00) begin
          st_nxt.rsp.rdata   = dq_sync;
          st_nxt.rsp.par_odd = ^dq_sync;
          st_nxt.rsp.done    = 1'b1;
          st_nxt.pins.ce_b   = 1'b1;
          st_nxt.pins.oe_b   = 1'b1;
          st_nxt.state       = FH_S_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end
      end
      // write pulse: data latches as write enable and select rise together
      FH_S_WR: begin
        if (st_r.cnt == 8'h00) begin
          st_nxt.pins.we_b = 1'b1;
          st_nxt.pins.ce_b = 1'b1;
          st_nxt.cnt       = GAP_WAIT;
          st_nxt.state     = FH_S_GAP;
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end
      end
      // hold data past the rising edge, then next write or finish
      FH_S_GAP: begin
        if (st_r.cnt != 8'h00) begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end else if (st_r.op == FH_OP_ID_OFF || st_r.step == 2'h2) begin
          st_nxt.pins.dq_oe = 1'b0;
          st_nxt.rsp.done   = 1'b1;
          st_nxt.state      = FH_S_IDLE;
        end else begin
          st_nxt.step      = st_r.step + 2'h1;
          st_nxt.pins.addr = {10'h000, cw_next[18:8]};
          st_nxt.pins.dq_o = cw_next[7:0];
          st_nxt.pins.ce_b = 1'b0;
          st_nxt.pins.we_b = 1'b0;
          st_nxt.cnt       = WP_WAIT;
          st_nxt.state     = FH_S_WR;
        end
      end
      FH_S_WAKE: begin
        if (st_r.cnt == 8'h00) begin
          st_nxt.rsp.done = 1'b1;
          st_nxt.state    = FH_S_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end
      end
    endcase
    st_nxt.ready = (st_nxt.state == FH_S_IDLE);
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  // reset starts in the wake wait so no read can beat the flash's own
  // wake-up after a system reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r.state        <= FH_S_WAKE;
      st_r.op           <= FH_OP_WAKE;
      st_r.cnt          <= WAKE_WAIT;
      st_r.step         <= 2'h0;
      st_r.ready        <= 1'b0;
      st_r.pins.addr    <= '0;
      st_r.pins.ce_b    <= 1'b1;
      st_r.pins.oe_b    <= 1'b1;
      st_r.pins.we_b    <= 1'b1;
      st_r.pins.reset_b <= 1'b1;
      st_r.pins.dq_o    <= 8'h00;
      st_r.pins.dq_oe   <= 1'b0;
      st_r.pins.hv_id_en <= 1'b0;
      st_r.rsp          <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------------------
  assign ready     = st_r.ready;
  assign rsp       = st_r.rsp;
  assign f_addr    = st_r.pins.addr;
  assign f_ce_b    = st_r.pins.ce_b;
  assign f_oe_b    = st_r.pins.oe_b;
  assign f_we_b    = st_r.pins.we_b;
  assign f_reset_b = st_r.pins.reset_b;
  assign f_dq_o    = st_r.pins.dq_o;
  assign f_dq_oe   = st_r.pins.dq_oe;
  assign hv_id_en  = st_r.pins.hv_id_en;

endmodule : fh_host

// ### hdl/fh_cfg.svh
// ---------------------------------------------------------------------------
// fh_cfg.svh
// ---------------------------------------------------------------------------
// timing counts, command words and field positions for the flash host.
// assumes a 200 MHz system clock; the access, wake and write counts below are derived from it.
`ifndef FH_CFG_SVH
`define FH_CFG_SVH

// ---------------------------------------------------------------------------
// clock and times
// ---------------------------------------------------------------------------
`define FH_CLK_PS      5000
// access time the host allows before sampling data (plain default)
`define FH_ACC_NS      100
// wake-up time after the flash reset pin is taken high
`define FH_WAKE_NS     500
// write-enable low pulse width used for command writes (plain default)
`define FH_WP_NS       50
// least times round up to whole cycles
`define FH_ACC_CYC     ((`FH_ACC_NS * 1000 + `FH_CLK_PS - 1) / `FH_CLK_PS)
`define FH_WAKE_CYC    ((`FH_WAKE_NS * 1000 + `FH_CLK_PS - 1) / `FH_CLK_PS)
`define FH_WP_CYC      ((`FH_WP_NS * 1000 + `FH_CLK_PS - 1) / `FH_CLK_PS)
// extra wait so sampled data has crossed the three-stage pin synchroniser
`define FH_SYNC_CYC    4
// idle cycles between two command writes
`define FH_GAP_CYC     2

// ---------------------------------------------------------------------------
// address fields
// ---------------------------------------------------------------------------
`define FH_ADDR_W      21
`define FH_GRP_LSB     18
`define FH_LOW_SEL_BIT 6
`define FH_PAGE_BIT    1
`define FH_BYTE_BIT    0

// ---------------------------------------------------------------------------
// command words
// ---------------------------------------------------------------------------
`define FH_UNLOCK1_A   11'h555
`define FH_UNLOCK1_D   8'hAA
`define FH_UNLOCK2_A   11'h2AA
`define FH_UNLOCK2_D   8'h55
`define FH_IDCMD_D     8'h90
`define FH_RESET_A     11'h000
`define FH_RESET_D     8'hF0

`endif

// ### hdl/fh_pkg.sv
// ---------------------------------------------------------------------------
// fh_pkg.sv
// ---------------------------------------------------------------------------
// types shared by the flash host and its pin synchroniser.
// assumes fh_cfg.svh is on the include path.
`include "fh_cfg.svh"

package fh_pkg;

  // operations the user side may request
  typedef enum logic [2:0] {
    FH_OP_READ   = 3'h0,  // array read at full address
    FH_OP_ID     = 3'h1,  // identifier read (maker, device or protect)
    FH_OP_ID_ON  = 3'h2,  // enter identifier mode by command
    FH_OP_ID_OFF = 3'h3,  // read/reset command, back to array reads
    FH_OP_HV_ON  = 3'h4,  // ask programming equipment for high voltage
    FH_OP_HV_OFF = 3'h5,  // withdraw the high-voltage request
    FH_OP_SLEEP  = 3'h6,  // hold flash reset low (standby)
    FH_OP_WAKE   = 3'h7   // release flash reset and wait wake-up time
  } fh_op_t;

  // which identifier byte an identifier read fetches
  typedef enum logic [1:0] {
    FH_ID_MAKER  = 2'h0,
    FH_ID_DEVICE = 2'h1,
    FH_ID_PROT   = 2'h2
  } fh_id_t;

  // one-hot controller states
  typedef enum logic [4:0] {
    FH_S_IDLE = 5'b00001,
    FH_S_RD   = 5'b00010,
    FH_S_WR   = 5'b00100,
    FH_S_GAP  = 5'b01000,
    FH_S_WAKE = 5'b10000
  } fh_state_t;

  // user request
  typedef struct packed {
    logic                      valid;
    fh_op_t                    op;
    logic [`FH_ADDR_W-1:0]     addr;   // array address for FH_OP_READ
    fh_id_t                    id_sel;
    logic [2:0]                group;  // sector group for protect reads
  } fh_req_t;

  // user answer
  typedef struct packed {
    logic       done;    // one-cycle pulse
    logic [7:0] rdata;
    logic       par_odd; // captured byte has odd parity
  } fh_rsp_t;

  // flash pins driven by the host
  typedef struct packed {
    logic [`FH_ADDR_W-1:0] addr;
    logic                  ce_b;
    logic                  oe_b;
    logic                  we_b;
    logic                  reset_b;
    logic [7:0]            dq_o;
    logic                  dq_oe;
    logic                  hv_id_en;
  } fh_pins_t;

  // whole controller state
  typedef struct packed {
    fh_state_t  state;
    fh_op_t     op;
    logic [7:0] cnt;
    logic [1:0] step;
    logic       ready;
    fh_pins_t   pins;
    fh_rsp_t    rsp;
  } fh_st_t;

endpackage : fh_pkg

// ### hdl/fh_pin_sync.sv
// ---------------------------------------------------------------------------
// fh_pin_sync.sv
// ---------------------------------------------------------------------------
// three-stage synchroniser for the flash data pins.
// assumes the pins change asynchronously to clk.
module fh_pin_sync
  import fh_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] pin_i,
  output      logic [W-1:0] sync_o
);

  // ---------------------------------------------------------------------------
  // per-bit stages
  // ---------------------------------------------------------------------------
  // a bit only moves once stages two and three agree, which filters the
  // single-cycle glitch a slow data edge can leave behind
  for (genvar b = 0; b < W; b++) begin : g_bit
    logic s1_r;  // metastability catcher, read only by s2
    logic s2_r;
    logic s3_r;
    logic out_r; // settled value
    // shift and settle
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        s1_r  <= 1'b0;
        s2_r  <= 1'b0;
        s3_r  <= 1'b0;
        out_r <= 1'b0;
      end else begin
        s1_r <= pin_i[b];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          out_r <= s3_r;
        end
      end
    end
    assign sync_o[b] = out_r;
  end

endmodule : fh_pin_sync

// ### tb/fh_host_props.sv
// checker for the flash host: pin timing and request answers.
// assumes one clock domain and the active-low asynchronous reset.
module fh_host_props
  import fh_pkg::*;
#(
  parameter int ACC_CYC  = 20,
  parameter int WAKE_CYC = 100,
  parameter int WP_CYC   = 10
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire fh_req_t     req,
  input wire logic        ready,
  input wire fh_rsp_t     rsp,
  input wire logic [20:0] f_addr,
  input wire logic        f_ce_b,
  input wire logic        f_oe_b,
  input wire logic        f_we_b,
  input wire logic        f_reset_b,
  input wire logic [7:0]  f_dq_o,
  input wire logic        f_dq_oe,
  input wire logic [7:0]  f_dq_i,
  input wire logic        hv_id_en
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------
  // latencies
  // ----------
  localparam int RD_LAT = ACC_CYC + 6;   // taken edge to done of a read
  localparam int WK_LAT = WAKE_CYC + 1;  // first wake cycle to done
  localparam int WE_LAT = WP_CYC + 1;    // write strobe low time
  logic take;                            // a request is taken this edge
  assign take = req.valid && ready;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  oe_clean_a: assert property (!f_oe_b |-> !f_ce_b && f_we_b && !f_dq_oe)
    else $error("output gate low outside a clean read");
  rd_addr_a: assert property (take && req.op == FH_OP_READ |=>
    !f_ce_b && !f_oe_b && f_addr == $past(req.addr)) else $error("read address wrong");
  rd_done_a: assert property (take && req.op == FH_OP_READ |->
    ##RD_LAT rsp.done && ready && f_ce_b) else $error("read done late or early");
  id_addr_a: assert property (take && req.op == FH_OP_ID |=> f_addr ==
    {$past(req.group), 16'h0000, $past(req.id_sel) == FH_ID_PROT,
     $past(req.id_sel) == FH_ID_DEVICE}) else $error("identifier address wrong");
  sleep_pin_a: assert property (take && req.op == FH_OP_SLEEP |=>
    !f_reset_b && rsp.done) else $error("sleep did not lower flash reset");
  wake_wait_a: assert property (take && req.op == FH_OP_WAKE |=>
    f_reset_b && !ready ##WK_LAT rsp.done && ready) else $error("wake wait wrong");
  hv_level_a: assert property (take &&
    (req.op == FH_OP_HV_ON || req.op == FH_OP_HV_OFF)
    |=> hv_id_en == ($past(req.op) == FH_OP_HV_ON)) else $error("hv request wrong");
  cmd_first_a: assert property (take &&
    (req.op == FH_OP_ID_ON || req.op == FH_OP_ID_OFF)
    |=> !f_we_b && !f_ce_b && f_dq_oe
    && f_addr[10:0] == ($past(req.op) == FH_OP_ID_ON ? 11'h555 : 11'h000)
    && f_dq_o == ($past(req.op) == FH_OP_ID_ON ? 8'hAA : 8'hF0)) else $error("bad command");
  we_width_a: assert property ($fell(f_we_b) |-> !f_ce_b ##WE_LAT f_we_b)
    else $error("write strobe width wrong");
endmodule : fh_host_props

bind fh_host fh_host_props #(.ACC_CYC(ACC_CYC), .WAKE_CYC(WAKE_CYC), .WP_CYC(WP_CYC))
  u_props (.clk(clk), .rst_b(rst_b), .req(req), .ready(ready), .rsp(rsp),
  .f_addr(f_addr), .f_ce_b(f_ce_b), .f_oe_b(f_oe_b), .f_we_b(f_we_b),
  .f_reset_b(f_reset_b), .f_dq_o(f_dq_o), .f_dq_oe(f_dq_oe), .f_dq_i(f_dq_i),
  .hv_id_en(hv_id_en));

// ### tb/fh_flash_model.sv
// behavioural model of the byte-wide flash on the far side of the host.
// assumes the bench resolves the data wire from both parties' enables.
module fh_flash_model #(
  parameter real        ACC_NS  = 100.0,
  parameter real        WAKE_NS = 500.0,
  parameter logic [7:0] MAKER   = 8'h07,  // arbitrary value, odd parity
  parameter logic [7:0] DEVICE  = 8'h8F,  // arbitrary value, odd parity
  parameter logic [7:0] PROT    = 8'hA5   // protect flag of each group
) (
  input  wire logic [20:0] addr,
  input  wire logic        ce_b,
  input  wire logic        oe_b,
  input  wire logic        we_b,
  input  wire logic        reset_b,
  input  wire logic        hv_id,
  input  wire logic [7:0]  dq_i,
  output      logic [7:0]  dq_o,
  output      logic        dq_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       id_cmd = 1'b0;  // powers up reading the array
  logic [1:0] unlk   = 2'h0;  // unlock writes seen so far
  logic       ok     = 1'b0;  // access and wake time both run out
  realtime    t_chg  = 0.0;
  realtime    t_wk   = 0.0;
  logic [7:0] val;

  // byte differs per sector so a bad sector decode shows
  function automatic logic [7:0] arr_byte(input logic [20:0] a);
    return a[7:0] ^ {a[20:16], a[10:8]};
  endfunction : arr_byte

  // wake time restarts on reset release
  always @(posedge reset_b) t_wk = $realtime;
  always @(addr, ce_b, oe_b) t_chg = $realtime;
  // polled, so the output settles up to 1 ns late; never early
  always #1 ok = ($realtime - t_chg >= ACC_NS) && ($realtime - t_wk >= WAKE_NS);

  // command latched on the rising write strobe
  always @(posedge we_b) begin
    if (dq_i == 8'hF0) id_cmd = 1'b0;
    else if (unlk == 2'h2 && addr[10:0] == 11'h555 && dq_i == 8'h90) id_cmd = 1'b1;
    unlk = (addr[10:0] == 11'h555 && dq_i == 8'hAA) ? 2'h1 :
           (unlk == 2'h1 && addr[10:0] == 11'h2AA && dq_i == 8'h55) ? 2'h2 : 2'h0;
  end

  always_comb begin
    if (hv_id || id_cmd) begin
      if (addr[1]) val = {7'h00, PROT[addr[20:18]]};
      else val = addr[0] ? DEVICE : MAKER;
    end else begin
      val = arr_byte(addr);
    end
  end

  // drive only when selected, gated and awake
  assign dq_en = !ce_b && !oe_b && reset_b;
  // not yet valid: inverse byte, so an early sample is caught
  assign dq_o  = ok ? val : ~val;
endmodule : fh_flash_model

// ### tb/tb_top.sv
// self-checking bench for the flash host with a flash model behind it.
// assumes shortened counts; the model's times follow them.
module tb_top
  import fh_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         ACC  = 2;
  localparam int         WAKE = 4;
  localparam int         WP   = 1;
  localparam logic [7:0] MK   = 8'h07;  // arbitrary value, odd parity
  localparam logic [7:0] DV   = 8'h8F;  // arbitrary value, odd parity
  localparam logic [7:0] PM   = 8'hA5;  // protected groups
  logic        clk, rst_b, ready, f_ce_b, f_oe_b, f_we_b, f_reset_b;
  logic        f_dq_oe, hv_id_en, m_en;
  logic [20:0] f_addr;
  logic [7:0]  f_dq_o, m_dq, dq_bus;
  logic [7:0]  flt = 8'h5A;  // released wire: changes every cycle
  fh_req_t     req;
  fh_rsp_t     rsp;
  int          err_count, samples_checked;

  fh_host #(.ACC_CYC(ACC), .WAKE_CYC(WAKE), .WP_CYC(WP)) dut (
    .clk(clk), .rst_b(rst_b), .req(req), .ready(ready), .rsp(rsp),
    .f_addr(f_addr), .f_ce_b(f_ce_b), .f_oe_b(f_oe_b), .f_we_b(f_we_b),
    .f_reset_b(f_reset_b), .f_dq_o(f_dq_o), .f_dq_oe(f_dq_oe), .f_dq_i(dq_bus),
    .hv_id_en(hv_id_en));
  fh_flash_model #(.ACC_NS(ACC * 5.0), .WAKE_NS(WAKE * 5.0), .MAKER(MK), .DEVICE(DV),
    .PROT(PM)) flash (.addr(f_addr), .ce_b(f_ce_b), .oe_b(f_oe_b), .we_b(f_we_b),
    .reset_b(f_reset_b), .hv_id(hv_id_en), .dq_i(dq_bus), .dq_o(m_dq), .dq_en(m_en));

  // wire level from both parties' enables
  assign dq_bus = f_dq_oe ? f_dq_o : (m_en ? m_dq : flt);
  always @(posedge clk) flt <= ~flt;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // one request: present after ready, drop valid once taken, wait for done
  task automatic do_op(input fh_op_t op, input logic [20:0] a, input fh_id_t s,
                       input logic [2:0] g);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) chk("ready level", 8'h01, 8'h00);
    @(posedge clk);
    req <= '{valid: 1'b1, op: op, addr: a, id_sel: s, group: g};
    @(posedge clk);
    req.valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp.done !== 1'b1 && n < 400);
    if (n >= 400) chk("done pulse", 8'h01, 8'h00);
  endtask : do_op

  // array reads from power-up, spread over sectors
  task automatic t_array;
    logic [20:0] al [4] = '{21'h000000, 21'h0A1234, 21'h17FEDC, 21'h1FFFFF};
    foreach (al[i]) begin
      do_op(FH_OP_READ, al[i], FH_ID_MAKER, 3'h0);
      chk("array byte", flash.arr_byte(al[i]), rsp.rdata);
      chk("parity flag", {7'h00, ^flash.arr_byte(al[i])}, {7'h00, rsp.par_odd});
    end
  endtask : t_array

  // identifier bytes and every group flag, then back to array reads
  task automatic t_ident(input fh_op_t on_op, input fh_op_t off_op);
    do_op(on_op, 21'h0, FH_ID_MAKER, 3'h0);
    do_op(FH_OP_ID, 21'h0, FH_ID_MAKER, 3'h5);
    chk("maker byte", MK, rsp.rdata);
    chk("maker parity", 8'h01, {7'h00, rsp.par_odd});
    do_op(FH_OP_ID, 21'h0, FH_ID_DEVICE, 3'h2);
    chk("device byte", DV, rsp.rdata);
    chk("id parity", 8'h01, {7'h00, rsp.par_odd});
    for (int g = 0; g < 8; g++) begin
      do_op(FH_OP_ID, 21'h0, FH_ID_PROT, g[2:0]);
      chk("group protect", {7'h00, PM[g]}, rsp.rdata);
    end
    do_op(off_op, 21'h0, FH_ID_MAKER, 3'h0);
    do_op(FH_OP_READ, 21'h000002, FH_ID_MAKER, 3'h0);
    chk("array after id", flash.arr_byte(21'h000002), rsp.rdata);
  endtask : t_ident

  // standby by reset pin, wake wait, then a read from the top sector
  task automatic t_standby;
    chk("idle select", 8'h01, {7'h00, f_ce_b});
    do_op(FH_OP_SLEEP, 21'h0, FH_ID_MAKER, 3'h0);
    chk("reset pin low", 8'h00, {7'h00, f_reset_b});
    chk("standby drive", 8'h00, {7'h00, m_en});
    do_op(FH_OP_WAKE, 21'h0, FH_ID_MAKER, 3'h0);
    chk("reset pin high", 8'h01, {7'h00, f_reset_b});
    do_op(FH_OP_READ, 21'h1FFFFF, FH_ID_MAKER, 3'h0);
    chk("read after wake", flash.arr_byte(21'h1FFFFF), rsp.rdata);
  endtask : t_standby

  initial begin
    rst_b = 1'b0;
    req = '0;
    err_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_array();
    t_ident(FH_OP_HV_ON, FH_OP_HV_OFF);
    t_ident(FH_OP_ID_ON, FH_OP_ID_OFF);
    t_standby();
    wrap_up();
  end

  // watchdog: the whole run needs well under this span
  initial begin
    #50000;
    err_count++;
    wrap_up();
  end
endmodule : tb_top
